/* File: hw/mct_pkg.sv */
// Package for the match/capture timer: register map, fields, reset values
package mct_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the plain register port)
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_PRESC = 8'h08;
  localparam logic [7:0] OFS_PCOUNT = 8'h0C;
  localparam logic [7:0] OFS_MCTRL = 8'h10;
  localparam logic [7:0] OFS_CCTRL = 8'h14;
  localparam logic [7:0] OFS_EXTM = 8'h18;
  localparam logic [7:0] OFS_PWM = 8'h1C;
  localparam logic [7:0] OFS_CLR = 8'h20;
  localparam logic [7:0] OFS_MATCH0 = 8'h40;
  localparam logic [7:0] OFS_ACTIVE0 = 8'h50;
  localparam logic [7:0] OFS_CAP0 = 8'h60;
  localparam logic [7:0] OFS_STRIDE = 8'h04;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_CRST = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_EDGE = 3;
  localparam int MC_INT = 0;
  localparam int MC_RST = 1;
  localparam int MC_STOP = 2;
  localparam int MC_RELOAD = 12;
  localparam int MC_DMA = 16;
  localparam int CC_RISE = 0;
  localparam int CC_FALL = 1;
  localparam int CC_INT = 2;
  localparam int EM_ACT = 4;
  localparam int CLR_EN = 0;
  localparam int CLR_CH = 1;
  localparam int CLR_FALL = 3;

  // ****************************************************************
  // Writable bits and reset values
  // ****************************************************************
  localparam logic [31:0] MSK_CTRL = 32'h0000001F;
  localparam logic [31:0] MSK_MCTRL = 32'h0003FFFF;
  localparam logic [31:0] MSK_CCTRL = 32'h00000FFF;
  localparam logic [31:0] MSK_EXTM = 32'h00000FFF;
  localparam logic [31:0] MSK_PWM = 32'h00000007;
  localparam logic [31:0] MSK_CLR = 32'h0000000F;
  localparam logic [31:0] RST_REG = 32'h00000000;

  // Action of a match output pin on its match
  typedef enum logic [1:0] {
    MCT_ACT_NONE,
    MCT_ACT_LOW,
    MCT_ACT_HIGH,
    MCT_ACT_TOGGLE
  } mct_act_type;

endpackage

/* File: hw/mct_timer.sv */
// Match/capture timer: 32-bit count, prescaler, four matches and captures
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module mct_timer #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register port
  input wire logic [mct_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // External clock and capture pins
  input wire logic i_ext_clk,
  input wire logic [3:0] i_cap,
  // Match pins, event requests
  output logic [3:0] o_match,
  output logic [3:0] o_match_irq,
  output logic [3:0] o_cap_irq,
  output logic [1:0] o_dma_req
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 8 and 32");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] mctrl;
    logic [31:0] cctrl;
    logic [31:0] extm;
    logic [31:0] pwm;
    logic [31:0] clr;
    logic [31:0] pr;
    logic [31:0] pc;
    logic [CNT_W-1:0] tc;
    logic [3:0][CNT_W-1:0] shadow;
    logic [3:0][CNT_W-1:0] active;
    logic [3:0][CNT_W-1:0] cap;
    logic [3:0] cap_prev;
    logic ext_prev;
    logic [3:0] m_irq;
    logic [3:0] c_irq;
    logic [1:0] dma;
    logic [31:0] rdata;
  } mct_state_type;

  mct_state_type q;
  mct_state_type d;

  // Address of channel i inside a block of four words
  function automatic logic [7:0] mct_chan_addr(input logic [7:0] base,
                                               input int idx);
    mct_chan_addr = 8'(base + 8'(idx * 4));
  endfunction

  // ****************************************************************
  // Decoded fields and events
  // ****************************************************************
  logic en;
  logic crst;
  logic mode;
  logic [1:0] edge_sel;
  logic ext_edge;
  logic tick;
  logic step;
  logic [3:0] hit;
  logic [3:0] m_int;
  logic [3:0] m_rst;
  logic [3:0] m_stop;
  logic [3:0] m_reload;
  logic [3:0] cap_evt;
  logic [3:0] c_int;
  logic [1:0] clr_ch;
  logic clr_evt;
  logic any_rst;
  logic any_stop;
  logic reload_pt;
  logic wr_count;

  // Control and capture-clear fields, count write strobe
  assign en = q.ctrl[mct_pkg::CTRL_EN];
  assign crst = q.ctrl[mct_pkg::CTRL_CRST];
  assign mode = q.ctrl[mct_pkg::CTRL_MODE];
  assign edge_sel = q.ctrl[mct_pkg::CTRL_EDGE +: 2];
  assign clr_ch = q.clr[mct_pkg::CLR_CH +: 2];
  assign wr_count = i_wr && (i_addr == mct_pkg::OFS_COUNT);

  // timer or counter
  // External clock is taken as synchronous; edges found against last sample
  assign ext_edge = (edge_sel[0] & i_ext_clk & ~q.ext_prev) |
                    (edge_sel[1] & ~i_ext_clk & q.ext_prev);
  assign tick = en & ~crst & (mode ? ext_edge : 1'b1);
  assign step = tick & (q.pc == q.pr);

  // Per-channel match and capture decode
  for (genvar i = 0; i < 4; i++) begin : g_chan
    assign m_int[i] = q.mctrl[3*i + mct_pkg::MC_INT];
    assign m_rst[i] = q.mctrl[3*i + mct_pkg::MC_RST];
    assign m_stop[i] = q.mctrl[3*i + mct_pkg::MC_STOP];
    assign m_reload[i] = q.mctrl[mct_pkg::MC_RELOAD + i];
    assign c_int[i] = q.cctrl[3*i + mct_pkg::CC_INT];
    // match compare
    // Compared at the step so a match acts once per count value
    assign hit[i] = step & (q.tc == q.active[i]);
    assign cap_evt[i] =
      (q.cctrl[3*i + mct_pkg::CC_RISE] & i_cap[i] & ~q.cap_prev[i]) |
      (q.cctrl[3*i + mct_pkg::CC_FALL] & ~i_cap[i] & q.cap_prev[i]);
  end

  assign clr_evt = q.clr[mct_pkg::CLR_EN] &
    (q.clr[mct_pkg::CLR_FALL] ? (~i_cap[clr_ch] & q.cap_prev[clr_ch])
                              : (i_cap[clr_ch] & ~q.cap_prev[clr_ch]));
  assign any_rst = |(hit & m_rst);
  assign any_stop = |(hit & m_stop);
  // safe load point
  // Start of a new cycle, so a PWM edge is never cut short
  assign reload_pt = any_rst | crst;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.ext_prev = i_ext_clk;
    d.cap_prev = i_cap;
    // match irq
    // Irq pulses follow matches whatever the match action
    d.m_irq = hit & m_int;
    d.c_irq = cap_evt & c_int;
    d.dma = hit[1:0] & q.mctrl[mct_pkg::MC_DMA +: 2];

    if (tick) begin
      d.pc = step ? 32'h00000000 : q.pc + 32'h00000001;
    end
    if (step) begin
      if (any_rst) begin
        d.tc = '0;
      end else if (!any_stop) begin
        d.tc = CNT_W'(q.tc + 1'b1);
      end
    end
    if (any_stop) begin
      d.ctrl[mct_pkg::CTRL_EN] = 1'b0;
    end
    if (clr_evt || crst) begin
      d.tc = '0;
      d.pc = 32'h00000000;
    end

    for (int i = 0; i < 4; i++) begin
      if (cap_evt[i]) begin
        d.cap[i] = q.tc;
      end
      if (!m_reload[i] || reload_pt) begin
        d.active[i] = q.shadow[i];
      end
      // single-edge PWM
      // Cycle start drives low, own match drives high; start wins a tie
      if (i < 3 && q.pwm[i]) begin
        if (hit[i]) begin
          d.extm[i] = 1'b1;
        end
        if (any_rst) begin
          d.extm[i] = 1'b0;
        end
      end else if (hit[i]) begin
        case (q.extm[mct_pkg::EM_ACT + 2*i +: 2])
          mct_pkg::MCT_ACT_LOW: d.extm[i] = 1'b0;
          mct_pkg::MCT_ACT_HIGH: d.extm[i] = 1'b1;
          mct_pkg::MCT_ACT_TOGGLE: d.extm[i] = ~q.extm[i];
          default: d.extm[i] = q.extm[i];
        endcase
      end
    end

    // Register writes land after hardware updates so software wins
    if (i_wr) begin
      if (i_addr == mct_pkg::OFS_CTRL) begin
        d.ctrl = i_wdata & mct_pkg::MSK_CTRL;
      end else if (i_addr == mct_pkg::OFS_COUNT) begin
        d.tc = i_wdata[CNT_W-1:0];
      end else if (i_addr == mct_pkg::OFS_PRESC) begin
        d.pr = i_wdata;
      end else if (i_addr == mct_pkg::OFS_MCTRL) begin
        d.mctrl = i_wdata & mct_pkg::MSK_MCTRL;
      end else if (i_addr == mct_pkg::OFS_CCTRL) begin
        d.cctrl = i_wdata & mct_pkg::MSK_CCTRL;
      end else if (i_addr == mct_pkg::OFS_EXTM) begin
        d.extm = i_wdata & mct_pkg::MSK_EXTM;
      end else if (i_addr == mct_pkg::OFS_PWM) begin
        d.pwm = i_wdata & mct_pkg::MSK_PWM;
      end else if (i_addr == mct_pkg::OFS_CLR) begin
        d.clr = i_wdata & mct_pkg::MSK_CLR;
      end
      for (int i = 0; i < 4; i++) begin
        if (i_addr == mct_chan_addr(mct_pkg::OFS_MATCH0, i)) begin
          d.shadow[i] = i_wdata[CNT_W-1:0];
        end
      end
    end

    // Read data stand only in the cycle after the strobe
    d.rdata = 32'h00000000;
    if (i_rd) begin
      if (i_addr == mct_pkg::OFS_CTRL) begin
        d.rdata = q.ctrl;
      end else if (i_addr == mct_pkg::OFS_COUNT) begin
        d.rdata = 32'(q.tc);
      end else if (i_addr == mct_pkg::OFS_PRESC) begin
        d.rdata = q.pr;
      end else if (i_addr == mct_pkg::OFS_PCOUNT) begin
        d.rdata = q.pc;
      end else if (i_addr == mct_pkg::OFS_MCTRL) begin
        d.rdata = q.mctrl;
      end else if (i_addr == mct_pkg::OFS_CCTRL) begin
        d.rdata = q.cctrl;
      end else if (i_addr == mct_pkg::OFS_EXTM) begin
        d.rdata = q.extm;
      end else if (i_addr == mct_pkg::OFS_PWM) begin
        d.rdata = q.pwm;
      end else if (i_addr == mct_pkg::OFS_CLR) begin
        d.rdata = q.clr;
      end
      for (int i = 0; i < 4; i++) begin
        if (i_addr == mct_chan_addr(mct_pkg::OFS_MATCH0, i)) begin
          d.rdata = 32'(q.shadow[i]);
        end else if (i_addr == mct_chan_addr(mct_pkg::OFS_ACTIVE0, i)) begin
          d.rdata = 32'(q.active[i]);
        end else if (i_addr == mct_chan_addr(mct_pkg::OFS_CAP0, i)) begin
          d.rdata = 32'(q.cap[i]);
        end
      end
    end
  end

  // State register; every field clears to zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_rdata = q.rdata;
  assign o_match = q.extm[3:0];
  assign o_match_irq = q.m_irq;
  assign o_cap_irq = q.c_irq;
  assign o_dma_req = q.dma;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_plain_step;
    step && !any_rst && !any_stop && !clr_evt && !crst && !wr_count;
  endsequence
  sequence s_hit0_int;
    hit[0] && m_int[0];
  endsequence

  property p_count_step;
    s_plain_step |=> q.tc == CNT_W'($past(q.tc) + 1'b1);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not advance on prescale wrap");
  property p_ext_hold;
    en && mode && !ext_edge && !clr_evt && !crst && !wr_count
      |=> $stable(q.tc) && $stable(q.pc);
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("counter mode moved without an external edge");
  property p_match_irq;
    s_hit0_int |=> o_match_irq[0] ##1 !o_match_irq[0] || $past(hit[0]);
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("match irq missing or stretched");
  property p_stop;
    hit[1] && m_stop[1] && !(i_wr && i_addr == mct_pkg::OFS_CTRL)
      |=> !en ##1 $stable(q.tc);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop match did not halt the counter");
  property p_reset;
    hit[0] && m_rst[0] && !wr_count |=> q.tc == '0 && q.pc == 32'h00000000;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset match did not zero the count");
  property p_shadow;
    m_reload[0] && !reload_pt |=> $stable(q.active[0]);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("active match changed outside a safe point");
  property p_pin_high;
    hit[2] && q.extm[mct_pkg::EM_ACT + 4 +: 2] == mct_pkg::MCT_ACT_HIGH &&
      !q.pwm[2] && !(i_wr && i_addr == mct_pkg::OFS_EXTM) |=> o_match[2];
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("match pin not driven high");
  property p_capture;
    cap_evt[3] |=> q.cap[3] == $past(q.tc);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy the count");
  property p_dma;
    hit[1] && q.mctrl[mct_pkg::MC_DMA + 1] |=> o_dma_req[1];
  endproperty
  a_dma: assert property (p_dma)
    else $error("DMA request missing after match");
  property p_clear;
    clr_evt && !wr_count |=> q.tc == '0 && q.pc == 32'h00000000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("capture clear did not zero count and prescaler");
  property p_pwm;
    q.pwm[0] && hit[0] && !any_rst &&
      !(i_wr && i_addr == mct_pkg::OFS_EXTM) |=> o_match[0];
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("PWM output not high after its match");
  property p_presc;
    tick && !step && !clr_evt |=> q.pc == $past(q.pc) + 32'h00000001;
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler did not increment");
endmodule // mct_timer

/* File: tb/mct_partner.sv */
// Pin-side model: external count clock and capture inputs
`timescale 1ns/1ps

module mct_partner (
  // Clock
  input wire logic i_clk,
  // Pins toward the timer
  output logic o_ext_clk,
  output logic [3:0] o_cap
);
  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Both pins idle low until a scenario moves them
  initial begin
    o_ext_clk = 1'b0;
    o_cap = 4'h0;
  end

  // Slow pulses, so the level sampler sees each phase for several cycles
  task automatic ext_pulses(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge i_clk);
      o_ext_clk <= 1'b1;
      repeat (hold) @(posedge i_clk);
      o_ext_clk <= 1'b0;
    end
  endtask

  // One capture line to a level, just after a rising edge
  task automatic cap_level(input int ch, input logic v);
    @(posedge i_clk);
    o_cap[ch] <= v;
  endtask
endmodule // mct_partner

/* File: tb/testbench.sv */
// Self-checking bench for the match/capture timer
`timescale 1ns/1ps

module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h00000000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic i_ext_clk;
  logic [3:0] i_cap;
  logic [3:0] o_match;
  logic [3:0] o_match_irq;
  logic [3:0] o_cap_irq;
  logic [1:0] o_dma_req;
  logic [9:0] evs;
  int fail_count = 0;
  int checks_done = 0;

  // All event pulses in one vector: match irq, capture irq, dma
  assign evs = {o_dma_req, o_cap_irq, o_match_irq};

  mct_timer dut (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_ext_clk(i_ext_clk),
    .i_cap(i_cap),
    .o_match(o_match),
    .o_match_irq(o_match_irq),
    .o_cap_irq(o_cap_irq),
    .o_dma_req(o_dma_req)
  );

  mct_partner u_pin (
    .i_clk(i_clk),
    .o_ext_clk(i_ext_clk),
    .o_cap(i_cap)
  );

  // 20 MHz clock
  always #25 i_clk = ~i_clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata, e);
  endtask

  // Bounded wait for one event pulse; pulses last one cycle
  task automatic wait_ev(input int b);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (evs[b] !== 1'b1 && n < 2000);
    check({31'h0, evs[b]}, 32'h1);
  endtask

  // Pin 2 after its match, other pins untouched
  function automatic logic [3:0] exp_pins(input int a, input logic [3:0] p);
    logic [3:0] r;
    r = p;
    case (a)
      1: r[2] = 1'b0;
      2: r[2] = 1'b1;
      3: r[2] = ~p[2];
      default: r[2] = p[2];
    endcase
    return r;
  endfunction

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cut a hang short, far beyond the expected run time
  initial begin
    #(50 * 40000);
    fail_count++;
    summarize();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [31:0] m, pr, c;
    logic [3:0] p;
    int n, k, hi;
    void'($urandom(73794));
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    // Reset values, reserved bits and an unmapped place
    rd_chk(mct_pkg::OFS_COUNT, 32'h0);
    wr(mct_pkg::OFS_CTRL, 32'hFFFFFFE0);
    rd_chk(mct_pkg::OFS_CTRL, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h0);
    $display("test reset done");
    // Reset match with irq and dma, continuous match inside the period
    for (int t = 0; t < 3; t++) begin
      pr = $urandom_range(3);
      m = $urandom_range(6, 2);
      wr(mct_pkg::OFS_CTRL, 32'h2);
      wr(mct_pkg::OFS_PRESC, pr);
      wr(mct_pkg::OFS_MATCH0, m);
      wr(mct_pkg::OFS_MATCH0 + 8'h04, 32'h1);
      wr(mct_pkg::OFS_MCTRL, 32'h3000B);
      wr(mct_pkg::OFS_CTRL, 32'h1);
      wait_ev(0);
      n = 0;
      k = 0;
      hi = 0;
      do begin
        @(posedge i_clk);
        #1 n++;
        k += int'(evs[1]);
        hi += int'(evs[8]) + int'(evs[9]);
      end while (evs[0] !== 1'b1 && n < 200);
      check(32'(n), (m + 1) * (pr + 1));
      check(32'(k), 32'h1);
      check(32'(hi), 32'h2);
    end
    $display("test period done");
    // Stop match freezes count at the matched value
    wr(mct_pkg::OFS_CTRL, 32'h2);
    wr(mct_pkg::OFS_PRESC, 32'h0);
    wr(mct_pkg::OFS_MATCH0 + 8'h04, 32'hA);
    wr(mct_pkg::OFS_MCTRL, 32'h28);
    wr(mct_pkg::OFS_CTRL, 32'h1);
    wait_ev(1);
    repeat (5) @(posedge i_clk);
    rd_chk(mct_pkg::OFS_COUNT, 32'hA);
    rd_chk(mct_pkg::OFS_CTRL, 32'h0);
    $display("test stop done");
    // Every pin action on match 2
    for (int a = 0; a < 4; a++) begin
      p = 4'($urandom_range(15));
      wr(mct_pkg::OFS_CTRL, 32'h2);
      wr(mct_pkg::OFS_MATCH0 + 8'h08, 32'h3);
      wr(mct_pkg::OFS_MCTRL, 32'hC0);
      wr(mct_pkg::OFS_EXTM, (32'(a) << 8) | 32'(p));
      wr(mct_pkg::OFS_CTRL, 32'h1);
      wait_ev(2);
      check({28'h0, o_match}, {28'h0, exp_pins(a, p)});
    end
    $display("test pins done");
    // Shadow value waits for a safe point while reload is set
    c = $urandom;
    wr(mct_pkg::OFS_CTRL, 32'h0);
    wr(mct_pkg::OFS_MCTRL, 32'h1000);
    wr(mct_pkg::OFS_MATCH0, c);
    rd_chk(mct_pkg::OFS_ACTIVE0, m);
    wr(mct_pkg::OFS_CTRL, 32'h2);
    rd_chk(mct_pkg::OFS_ACTIVE0, c);
    $display("test shadow done");
    // Rising edge on capture 3 snapshots a held count
    wr(mct_pkg::OFS_CTRL, 32'h0);
    wr(mct_pkg::OFS_COUNT, c);
    wr(mct_pkg::OFS_CCTRL, 32'hA00);
    u_pin.cap_level(3, 1'b1);
    wait_ev(7);
    rd_chk(mct_pkg::OFS_CAP0 + 8'h0C, c);
    // Capture 0 edge clears count and prescaler
    wr(mct_pkg::OFS_CLR, 32'h1);
    wr(mct_pkg::OFS_CTRL, 32'h5);
    u_pin.cap_level(0, 1'b1);
    repeat (3) @(posedge i_clk);
    rd_chk(mct_pkg::OFS_COUNT, 32'h0);
    rd_chk(mct_pkg::OFS_PCOUNT, 32'h0);
    wr(mct_pkg::OFS_CLR, 32'h0);
    $display("test capture done");
    // External clock rising edges are counted
    n = $urandom_range(9, 3);
    wr(mct_pkg::OFS_COUNT, 32'h0);
    wr(mct_pkg::OFS_CTRL, 32'hD);
    u_pin.ext_pulses(n, 3);
    repeat (4) @(posedge i_clk);
    rd_chk(mct_pkg::OFS_COUNT, 32'(n));
    // Falling edges only, with shorter phases
    wr(mct_pkg::OFS_COUNT, 32'h0);
    wr(mct_pkg::OFS_CTRL, 32'h15);
    u_pin.ext_pulses(n, 2);
    repeat (4) @(posedge i_clk);
    rd_chk(mct_pkg::OFS_COUNT, 32'(n));
    $display("test counter done");
    // PWM on pin 0: high from match 0 until the reset match 3
    m = $urandom_range(6, 1);
    wr(mct_pkg::OFS_CTRL, 32'h2);
    wr(mct_pkg::OFS_MCTRL, 32'h400);
    wr(mct_pkg::OFS_MATCH0, m);
    wr(mct_pkg::OFS_MATCH0 + 8'h0C, 32'h7);
    wr(mct_pkg::OFS_PWM, 32'h1);
    wr(mct_pkg::OFS_EXTM, 32'h0);
    wr(mct_pkg::OFS_CTRL, 32'h1);
    repeat (20) @(posedge i_clk);
    hi = 0;
    repeat (16) begin
      @(posedge i_clk);
      #1 hi += int'(o_match[0]);
    end
    check(32'(hi), 32'h2 * (32'h7 - m));
    $display("test pwm done");
    summarize();
  end
endmodule // testbench
